// file: tsbr_map.vh
// constants for the transmit serial byte request port
`ifndef TSBR_MAP_VH
`define TSBR_MAP_VH
`define TSBR_BYTE_W        8
`define TSBR_FIFO_DEPTH    8
`define TSBR_FIFO_AW       3
`define TSBR_SCLK_DIV      2
`define TSBR_SCLK_DIV_W    2
`define TSBR_BIT_CNT_W     3
`define TSBR_MSB_POS       3'h7
`define TSBR_LAST_POS      3'h0
`define TSBR_REQ_DROP_POS  3'h1
`endif

// file: tsbr_fifo.v
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module tsbr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             core_clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [AW:0]      count_o
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      cnt_reg;
    wire            push;
    wire            pop;

    assign in_ready_o  = (cnt_reg != DEPTH[AW:0]);
    assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign count_o     = cnt_reg;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // storage written by index, no reset needed on data
    always @(posedge core_clk_i)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers and fill level
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            cnt_reg    <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop)
            begin
                cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
            end
            else if (pop && !push)
            begin
                cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// file: tsbr_port.v
// transmit serial byte request port: clock, request, frame out; bytes into fifo
`timescale 1ns/1ps
`include "tsbr_map.vh"
module tsbr_port (
    input  wire       core_clk_i,
    input  wire       rst_i,
    input  wire       frame_start_i,
    input  wire       enable_i,
    input  wire       transmit_byte_marker_i,
    input  wire       transmit_serial_line_i,
    output reg        serial_clk_o,
    output reg        transmit_byte_request_o,
    output reg        frame_strobe_o,
    output wire [7:0] enc_data_o,
    output wire       enc_valid_o,
    input  wire       enc_ready_i,
    output reg        overrun_o
);
    localparam ST_IDLE = 1'b0;
    localparam ST_SHIFT = 1'b1;

    reg [`TSBR_SCLK_DIV_W-1:0] div_reg;
    reg                        state_reg;
    reg                        state_next;
    reg [`TSBR_BIT_CNT_W-1:0]  bit_reg;
    reg [`TSBR_BIT_CNT_W-1:0]  bit_next;
    reg [`TSBR_BYTE_W-1:0]     shift_reg;
    reg [`TSBR_BYTE_W-1:0]     shift_next;
    reg                        push_reg;
    reg [`TSBR_BYTE_W-1:0]     push_data_reg;
    reg                        frame_pend_reg;
    reg                        mark_s1_reg;
    reg                        mark_s2_reg;
    reg                        data_s1_reg;
    reg                        data_s2_reg;
    wire                       fifo_ready;
    wire [`TSBR_FIFO_AW:0]     fifo_count;
    wire                       rise;
    wire                       fall;
    wire                       room;

    // request needs room beyond the stored bytes and one slot for a byte in flight or a waiting push, counted once
    function has_room;
        input [`TSBR_FIFO_AW:0] cnt;
        input                   busy;
        begin
            has_room = ({1'b0, cnt} + {4'h0, busy} + 5'h01) < 5'h08 + 5'h01;
        end
    endfunction

    assign room = has_room(fifo_count, state_reg | push_reg) & enable_i;

    // serial clock divided from the core clock; edges known one cycle ahead
    assign rise = (div_reg == 2'h1) & ~serial_clk_o;
    assign fall = (div_reg == 2'h1) & serial_clk_o;
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            div_reg      <= 2'h0;
            serial_clk_o <= 1'b0;
        end
        else
        begin
            div_reg <= (div_reg == 2'h1) ? 2'h0 : div_reg + 2'h1;
            if (div_reg == 2'h1)
            begin
                serial_clk_o <= ~serial_clk_o;
            end
        end
    end

    // link inputs pass two flops; framer edges settle well before our rising edge
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            mark_s1_reg <= 1'b0;
            mark_s2_reg <= 1'b0;
            data_s1_reg <= 1'b0;
            data_s2_reg <= 1'b0;
        end
        else
        begin
            mark_s1_reg <= transmit_byte_marker_i;
            mark_s2_reg <= mark_s1_reg;
            data_s1_reg <= transmit_serial_line_i;
            data_s2_reg <= data_s1_reg;
        end
    end

    // capture sequencer, advances only on rising serial edges
    always @*
    begin
        state_next = state_reg;
        bit_next   = bit_reg;
        shift_next = shift_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (rise && mark_s2_reg)
                begin
                    shift_next = {shift_reg[6:0], data_s2_reg};
                    bit_next   = `TSBR_MSB_POS - 3'h1;
                    state_next = ST_SHIFT;
                end
            end
            ST_SHIFT:
            begin
                if (rise)
                begin
                    shift_next = {shift_reg[6:0], data_s2_reg};
                    bit_next   = bit_reg - 3'h1;
                    if (bit_reg == `TSBR_LAST_POS)
                    begin
                        state_next = ST_IDLE;
                    end
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // sequencer registers and hand-off to the buffer
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            state_reg     <= ST_IDLE;
            bit_reg       <= 3'h0;
            shift_reg     <= 8'h00;
            push_reg      <= 1'b0;
            push_data_reg <= 8'h00;
            overrun_o     <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            bit_reg   <= bit_next;
            shift_reg <= shift_next;
            if (state_reg == ST_SHIFT && rise && bit_reg == `TSBR_LAST_POS)
            begin
                push_reg      <= 1'b1;
                push_data_reg <= shift_next;
                overrun_o     <= push_reg & ~fifo_ready;
            end
            else if (push_reg && fifo_ready)
            begin
                push_reg <= 1'b0;
            end
        end
    end

    // request changes only on falling edges; in a byte it is re-decided after bit 1
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            transmit_byte_request_o <= 1'b0;
        end
        else if (fall)
        begin
            if (state_reg == ST_IDLE)
            begin
                transmit_byte_request_o <= room;
            end
            else if (bit_reg == `TSBR_REQ_DROP_POS - 3'h1)
            begin
                transmit_byte_request_o <= room;
            end
            else if (bit_reg == `TSBR_MSB_POS - 3'h1)
            begin
                transmit_byte_request_o <= 1'b0;
            end
        end
    end

    // frame strobe: one serial clock wide, launched on a rising edge
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            frame_pend_reg <= 1'b0;
            frame_strobe_o <= 1'b0;
        end
        else
        begin
            // rise wins: a start that lands on a rise is taken at once, so the strobe is not stretched
            if (rise)
            begin
                frame_pend_reg <= 1'b0;
            end
            else if (frame_start_i)
            begin
                frame_pend_reg <= 1'b1;
            end
            if (rise)
            begin
                frame_strobe_o <= frame_pend_reg | frame_start_i;
            end
        end
    end

    tsbr_fifo #(
        .WIDTH (`TSBR_BYTE_W),
        .DEPTH (`TSBR_FIFO_DEPTH),
        .AW    (`TSBR_FIFO_AW)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .in_data_i   (push_data_reg),
        .in_valid_i  (push_reg),
        .in_ready_o  (fifo_ready),
        .out_data_o  (enc_data_o),
        .out_valid_o (enc_valid_o),
        .out_ready_i (enc_ready_i),
        .count_o     (fifo_count)
    );
endmodule

// file: tsbr_framer_model.sv
// framer model: queued bytes go out msb first under request and marker
`timescale 1ns/1ps
module tsbr_framer_model (
    input  wire  sclk_i,
    input  wire  req_i,
    input  wire  frame_i,
    input  int   gap_i,
    output logic marker_o,
    output logic line_o
);
    logic [7:0] q[$];
    logic [7:0] cur;
    int         left = 0;
    int         idle_n = 0;
    logic       in_frame = 1'b0;
    initial marker_o = 1'b0;
    initial line_o = 1'b0;
    task put(input logic [7:0] b);
        q.push_back(b);
    endtask
    // request is ignored until the frame strobe has been seen
    always @(posedge frame_i)
        in_frame = 1'b1;
    // everything moves just after the rising serial edge
    always @(posedge sclk_i)
    begin
        if (left != 0)
        begin
            marker_o <= 1'b0;
            line_o <= cur[left-1];
            left <= left - 1;
        end
        else if (req_i && in_frame && q.size() != 0 && idle_n >= gap_i)
        begin
            cur = q.pop_front();
            marker_o <= 1'b1;
            line_o <= cur[7];
            left <= 7;
            idle_n <= 0;
        end
        else
        begin
            marker_o <= 1'b0;
            line_o <= ~line_o; // unmarked junk, must never be taken
            idle_n <= idle_n + 1;
        end
    end
endmodule

// file: tsbr_port_assertions.sv
// concurrent checks on the ports of the transmit serial byte port
`timescale 1ns/1ps
module tsbr_port_assertions (
    input wire       core_clk_i,
    input wire       rst_i,
    input wire       frame_start_i,
    input wire       enable_i,
    input wire       transmit_byte_marker_i,
    input wire       serial_clk_o,
    input wire       transmit_byte_request_o,
    input wire       frame_strobe_o,
    input wire [7:0] enc_data_o,
    input wire       enc_valid_o,
    input wire       enc_ready_i,
    input wire       overrun_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [5:0] since_mark;
    // age of the last marker, saturating so it cannot wrap
    always @(posedge core_clk_i)
        if (rst_i || transmit_byte_marker_i)
            since_mark <= 6'h00;
        else if (since_mark != 6'h3f)
            since_mark <= since_mark + 6'h01;
    clk_high_a: assert property ($rose(serial_clk_o) |-> serial_clk_o[*2] ##1 !serial_clk_o)
        else $error("serial clock high phase wrong");
    clk_low_a: assert property ($fell(serial_clk_o) |-> !serial_clk_o[*2] ##1 serial_clk_o)
        else $error("serial clock low phase wrong");
    req_edge_a: assert property ($changed(transmit_byte_request_o) |-> $fell(serial_clk_o))
        else $error("request moved off a falling edge");
    req_enable_a: assert property ($rose(transmit_byte_request_o) |-> $past(enable_i))
        else $error("request raised while disabled");
    // an empty buffer always leaves room, so a drop then is never the allowed re-decision after bit 1
    req_hold_a: assert property (transmit_byte_request_o && enable_i && !enc_valid_o && since_mark > 6'h0c
        |=> transmit_byte_request_o)
        else $error("request dropped while waiting for marker");
    no_overrun_a: assert property (!overrun_o)
        else $error("byte arrived without buffer room");
    strobe_len_a: assert property ($rose(frame_strobe_o) |-> $rose(serial_clk_o) ##0 frame_strobe_o[*4]
        ##1 !frame_strobe_o)
        else $error("frame strobe not one serial period");
    strobe_due_a: assert property (frame_start_i |-> ##[1:8] $rose(frame_strobe_o))
        else $error("frame strobe missing");
    valid_hold_a: assert property (enc_valid_o && !enc_ready_i |=> enc_valid_o && $stable(enc_data_o))
        else $error("buffer head changed while stalled");
    marked_byte_a: assert property ($rose(enc_valid_o) |-> since_mark < 6'h2c)
        else $error("byte delivered without recent marker");
    cover property ($fell(transmit_byte_marker_i) ##28 transmit_byte_marker_i);
    cover property ((enc_valid_o && !enc_ready_i)[*8]);
    cover property ($rose(frame_strobe_o));
endmodule
bind tsbr_port tsbr_port_assertions chk_u (.*);

// file: tsbr_port_test.sv
// self-checking bench for the transmit serial byte port
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tsbr_port_test;
    typedef struct { logic [7:0] d; int gap; logic [7:0] e; } tsbr_row_t;
    logic       core_clk_i, rst_i, frame_start_i, enable_i, enc_ready_i;
    wire        sclk, req, fstr, mark, line, env, ovr;
    wire  [7:0] edata;
    logic [7:0] want;
    logic [7:0] exp_q[$];
    int         fails = 0;
    int         n_checks = 0;
    int         gap = 0;
    tsbr_row_t  rows[6] = '{'{8'ha5, 0, 8'ha5}, '{8'h01, 0, 8'h01}, '{8'h80, 0, 8'h80},
                            '{8'hff, 3, 8'hff}, '{8'h00, 1, 8'h00}, '{8'h5a, 0, 8'h5a}};
    tsbr_port dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .frame_start_i(frame_start_i),
        .enable_i(enable_i), .transmit_byte_marker_i(mark), .transmit_serial_line_i(line),
        .serial_clk_o(sclk), .transmit_byte_request_o(req), .frame_strobe_o(fstr),
        .enc_data_o(edata), .enc_valid_o(env), .enc_ready_i(enc_ready_i), .overrun_o(ovr));
    tsbr_framer_model fm_u (.sclk_i(sclk), .req_i(req), .frame_i(fstr), .gap_i(gap),
        .marker_o(mark), .line_o(line));
    task stop_test();
        if (fails == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task send(input logic [7:0] b);
        exp_q.push_back(b);
        fm_u.put(b);
    endtask
    // wait, bounded, until every queued byte has been popped
    task drain();
        repeat (3000) if (exp_q.size() != 0) @(posedge core_clk_i);
        `CHK("drained", 0, exp_q.size())
    endtask
    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    // every popped byte must be the next one sent, in order, msb first
    // looked at mid-cycle, where the head byte is settled before the edge that pops it
    always @(negedge core_clk_i)
        if (!rst_i && env === 1'b1 && enc_ready_i)
        begin
            want = exp_q.pop_front();
            `CHK("enc_data", want, edata)
        end
    // hang guard, far beyond the thousand or so cycles needed
    initial
    begin
        #300000;
        fails++;
        stop_test();
    end
    initial
    begin
        rst_i = 1'b1;
        frame_start_i = 1'b0;
        enable_i = 1'b0;
        enc_ready_i = 1'b1;
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        `CHK("req_rst", 1'b0, req)
        `CHK("valid_rst", 1'b0, env)
        send(8'h3c);
        repeat (40) @(posedge core_clk_i);
        `CHK("req_disabled", 1'b0, req)
        enable_i <= 1'b1;
        repeat (40) @(posedge core_clk_i);
        `CHK("req_up", 1'b1, req)
        `CHK("before_frame", 1'b0, env)
        frame_start_i <= 1'b1;
        @(posedge core_clk_i);
        frame_start_i <= 1'b0;
        foreach (rows[i])
        begin
            gap <= rows[i].gap;
            exp_q.push_back(rows[i].e);
            fm_u.put(rows[i].d);
            if (rows[i].gap != 0)
                drain();
        end
        drain();
        // stalled consumer: the buffer fills and request must stay down
        enc_ready_i <= 1'b0;
        for (int i = 0; i < 10; i++)
            send(8'h10 + 8'(i));
        repeat (600) @(posedge core_clk_i);
        `CHK("full_req", 1'b0, req)
        `CHK("held_back", 2, fm_u.q.size())
        enc_ready_i <= 1'b1;
        drain();
        `CHK("overrun", 1'b0, ovr)
        stop_test();
    end
endmodule
